/* File: hw/pdm_defs.svh */
/*
 * constants of the port data multiplexer control: pin indexes, crossbar
 * channel codes and endpoint identity values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

// port pin indexes into every 6-bit pin vector
`define PDM_PIN_TP 3'h0
`define PDM_PIN_TN 3'h1
`define PDM_PIN_BP 3'h2
`define PDM_PIN_BN 3'h3
`define PDM_PIN_S1 3'h4
`define PDM_PIN_S2 3'h5
`define PDM_NPIN 6

// crossbar channel code of an external serial pin, 0 = unmapped
`define PDM_XCH_NONE 2'h0
// bypass: external pin 0 is the receive pin, pin 1 the transmit pin
`define PDM_XOE_BYPASS 2'h2
// idle level of an unsourced serial line
`define PDM_SER_IDLE 1'h1

// endpoint: usb device class code of a billboard device
`define PDM_EP_CLASS_BILLBOARD 8'h11
// endpoint: only control endpoint zero exists
`define PDM_EP_NUM_MAX 4'h0

`endif

/* File: hw/pdm_pkg.sv */
/*
 * types of the port data multiplexer control.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package pdm_pkg;

	// first-stage source of a usb pair
	typedef enum logic [2:0] {
		PDM_SRC_NONE,
		PDM_SRC_ROOT,
		PDM_SRC_ENDPT,
		PDM_SRC_AUX,
		PDM_SRC_SERIAL
	} pdm_src_t;

	// first-stage source of the sideband pair
	typedef enum logic [1:0] {
		PDM_SBU_NONE,
		PDM_SBU_AUX,
		PDM_SBU_SERIAL
	} pdm_sbu_src_t;

	typedef struct packed {
		pdm_src_t top_src;
		pdm_src_t bot_src;
		pdm_sbu_src_t sbu_src;
	} pdm_route_t;

	// second-stage state, already in connector orientation
	typedef struct packed {
		pdm_src_t top_sel;
		pdm_src_t bot_sel;
		pdm_sbu_src_t sbu_sel;
		logic sbu_swap;
	} pdm_sw_t;

	typedef struct packed {
		logic [1:0] dir;
		logic [1:0] ch1;
		logic [1:0] ch0;
	} pdm_xbar_t;

	// charger switches, bit order tp, tn, bp, bn from bit 0
	typedef struct packed {
		logic [3:0] adc_route;
		logic [3:0] charger_sink_current;
		logic [3:0] charger_force_voltage;
	} pdm_chg_t;

endpackage : pdm_pkg

/* File: hw/pdm_edge_det.sv */
/*
 * switching-event detectors for the port inputs, one per bit.
 * assumes inputs synchronous to clk_sys_i.
 */
`timescale 1ns/100ps
module pdm_edge_det #(
	parameter int W = 6
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] en_i,
	input wire logic [W-1:0] din_i,
	output logic [W-1:0] evt_o
);
	logic [W-1:0] hist_q;
	logic [W-1:0] armed_q;
	logic [W-1:0] evt_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// history is refreshed while disabled so enabling never fires
			always_ff @(posedge clk_sys_i) begin
				if (sys_rst_i) begin
					hist_q[i] <= 1'b0;
					armed_q[i] <= 1'b0;
					evt_q[i] <= 1'b0;
				end else begin
					hist_q[i] <= din_i[i];
					armed_q[i] <= en_i[i];
					evt_q[i] <= en_i[i] & armed_q[i] & (din_i[i] ^ hist_q[i]);
				end
			end
		end
	endgenerate

	assign evt_o = evt_q;

endmodule : pdm_edge_det

/* File: hw/pdm_port_mux.sv */
/*
 * port data multiplexer control: pair and sideband swap, serial crossbar
 * with power-up bypass, comparators, pulls, clamps, endpoint pull-up and
 * charger detection switches.
 * assumes all inputs synchronous to clk_sys_i and a single orientation
 * input from the cable detection logic.
 */
// Functional notes
// - swap top and bottom pairs with orientation
// - root, endpoint, aux pairs routable top or bottom
// - serial 0 top, 1 bottom, 2 sideband only
// - aux on sideband one/two, swapped when flipped
// - external serial pins and crossbar firmware configurable
// - power-up bypass copies receive pin to transmit
// - enableable comparators flag port input switching events
// - per-pin configurable pull-up and pull-down
// - clamp attached only while second stage closed
// - endpoint low speed, endpoint zero only
// - endpoint enumerates as billboard class
// - endpoint pull-up off while transmitting
// - receive pull-up on top or bottom minus line
// - contact detect sources on oriented pair
// - twelve independent charger detection switches
`timescale 1ns/100ps
`include "pdm_defs.svh"
module pdm_port_mux (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic orient_flip_i,
	input wire pdm_pkg::pdm_route_t route_i,
	output pdm_pkg::pdm_sw_t sw_o,
	input wire logic [5:0] port_in_i,
	output logic [5:0] port_out_o,
	output logic [5:0] port_oe_o,
	input wire logic [1:0] xpin_in_i,
	output logic [1:0] xpin_out_o,
	output logic [1:0] xpin_oe_o,
	input wire pdm_pkg::pdm_xbar_t xbar_cfg_i,
	input wire logic xbar_load_i,
	output logic xbar_bypass_o,
	input wire logic [5:0] cmp_en_i,
	output logic [5:0] cmp_event_o,
	input wire logic [5:0] pull_up_i,
	input wire logic [5:0] pull_dn_i,
	output logic [5:0] pull_up_o,
	output logic [5:0] pull_dn_o,
	output logic [5:0] clamp_en_o,
	input wire logic ep_attach_i,
	input wire logic ep_tx_i,
	output logic [1:0] endpoint_pullup_o,
	output logic ep_low_speed_o,
	output logic [7:0] ep_dev_class_o,
	output logic [3:0] ep_num_max_o,
	input wire logic dcd_en_i,
	output logic [1:0] contact_detect_current_o,
	output logic [1:0] contact_detect_pulldown_o,
	input wire pdm_pkg::pdm_chg_t chg_i,
	output pdm_pkg::pdm_chg_t chg_o
);
	pdm_pkg::pdm_sw_t sw_d;
	pdm_pkg::pdm_sw_t sw_q;
	pdm_pkg::pdm_xbar_t xcfg_q;
	logic bypass_q;
	logic [5:0] closed_d;
	logic [2:0] ch_act;
	logic [2:0] ch_pos [3];
	logic [2:0] ch_neg [3];
	logic [2:0] ch_tx;
	logic [2:0] ch_rx;
	logic [5:0] pout_d;
	logic [5:0] poe_d;
	logic [5:0] pout_q;
	logic [5:0] poe_q;
	logic [1:0] xout_d;
	logic [1:0] xoe_d;
	logic [1:0] xout_q;
	logic [1:0] xoe_q;
	logic [5:0] pu_q;
	logic [5:0] pd_q;
	logic [5:0] clamp_q;
	logic [1:0] eppu_q;
	logic [1:0] dcd_i_q;
	logic [1:0] dcd_r_q;
	pdm_pkg::pdm_chg_t chg_q;

	// second stage follows the orientation for every pair
	always_comb begin
		sw_d.top_sel = orient_flip_i ? route_i.bot_src : route_i.top_src;
		sw_d.bot_sel = orient_flip_i ? route_i.top_src : route_i.bot_src;
		sw_d.sbu_sel = route_i.sbu_src;
		sw_d.sbu_swap = orient_flip_i;
		closed_d[`PDM_PIN_TP] = sw_d.top_sel != pdm_pkg::PDM_SRC_NONE;
		closed_d[`PDM_PIN_TN] = sw_d.top_sel != pdm_pkg::PDM_SRC_NONE;
		closed_d[`PDM_PIN_BP] = sw_d.bot_sel != pdm_pkg::PDM_SRC_NONE;
		closed_d[`PDM_PIN_BN] = sw_d.bot_sel != pdm_pkg::PDM_SRC_NONE;
		closed_d[`PDM_PIN_S1] = sw_d.sbu_sel != pdm_pkg::PDM_SBU_NONE;
		closed_d[`PDM_PIN_S2] = sw_d.sbu_sel != pdm_pkg::PDM_SBU_NONE;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sw_q <= '0;
			clamp_q <= 6'h00;
		end else begin
			sw_q <= sw_d;
			clamp_q <= closed_d;
		end
	end

	// serial channel placement: 0 on top mux, 1 on bottom mux, 2 on sideband
	always_comb begin
		ch_act[0] = route_i.top_src == pdm_pkg::PDM_SRC_SERIAL;
		ch_act[1] = route_i.bot_src == pdm_pkg::PDM_SRC_SERIAL;
		ch_act[2] = route_i.sbu_src == pdm_pkg::PDM_SBU_SERIAL;
		ch_pos[0] = orient_flip_i ? `PDM_PIN_BP : `PDM_PIN_TP;
		ch_neg[0] = orient_flip_i ? `PDM_PIN_BN : `PDM_PIN_TN;
		ch_pos[1] = orient_flip_i ? `PDM_PIN_TP : `PDM_PIN_BP;
		ch_neg[1] = orient_flip_i ? `PDM_PIN_TN : `PDM_PIN_BN;
		ch_pos[2] = orient_flip_i ? `PDM_PIN_S2 : `PDM_PIN_S1;
		ch_neg[2] = orient_flip_i ? `PDM_PIN_S1 : `PDM_PIN_S2;
	end

	// crossbar: an input pin feeds a channel's transmit, an output pin
	// shows a channel's receive
	genvar c;
	generate
		for (c = 0; c < 3; c++) begin : g_ch
			localparam logic [1:0] CODE = 2'(c + 1);
			always_comb begin
				ch_tx[c] = `PDM_SER_IDLE;
				if (!bypass_q && !xcfg_q.dir[0] && xcfg_q.ch0 == CODE) begin
					ch_tx[c] = xpin_in_i[0];
				end else if (!bypass_q && !xcfg_q.dir[1] && xcfg_q.ch1 == CODE) begin
					ch_tx[c] = xpin_in_i[1];
				end
				ch_rx[c] = ch_act[c] ? port_in_i[ch_neg[c]] : `PDM_SER_IDLE;
			end
		end
	endgenerate

	always_comb begin
		pout_d = 6'h3f;
		poe_d = 6'h00;
		for (int k = 0; k < 3; k++) begin
			if (ch_act[k]) begin
				pout_d[ch_pos[k]] = ch_tx[k];
				poe_d[ch_pos[k]] = 1'b1;
			end
		end
	end

	always_comb begin
		if (bypass_q) begin
			xout_d = {xpin_in_i[0], `PDM_SER_IDLE};
			xoe_d = `PDM_XOE_BYPASS;
		end else begin
			xout_d[0] = (xcfg_q.ch0 == `PDM_XCH_NONE) ? `PDM_SER_IDLE
				: ch_rx[xcfg_q.ch0 - 2'h1];
			xout_d[1] = (xcfg_q.ch1 == `PDM_XCH_NONE) ? `PDM_SER_IDLE
				: ch_rx[xcfg_q.ch1 - 2'h1];
			xoe_d = xcfg_q.dir;
		end
	end

	// bypass holds from reset until firmware loads a crossbar map
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			bypass_q <= 1'b1;
			xcfg_q <= '0;
		end else if (xbar_load_i) begin
			bypass_q <= 1'b0;
			xcfg_q <= xbar_cfg_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pout_q <= 6'h3f;
			poe_q <= 6'h00;
			xout_q <= 2'h3;
			xoe_q <= 2'h0;
		end else begin
			pout_q <= pout_d;
			poe_q <= poe_d;
			xout_q <= xout_d;
			xoe_q <= xoe_d;
		end
	end

	pdm_edge_det #(
		.W(`PDM_NPIN)
	) u_cmp (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.en_i(cmp_en_i),
		.din_i(port_in_i),
		.evt_o(cmp_event_o)
	);

	// pull-down wins when both pulls are requested on one pin
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pu_q <= 6'h00;
			pd_q <= 6'h00;
		end else begin
			pu_q <= pull_up_i & ~pull_dn_i;
			pd_q <= pull_dn_i;
		end
	end

	// endpoint pull-up and contact detect sources, bit 0 top, bit 1 bottom
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			eppu_q <= 2'h0;
			dcd_i_q <= 2'h0;
			dcd_r_q <= 2'h0;
		end else begin
			eppu_q[0] <= ep_attach_i & ~ep_tx_i & ~orient_flip_i;
			eppu_q[1] <= ep_attach_i & ~ep_tx_i & orient_flip_i;
			dcd_i_q <= {dcd_en_i & orient_flip_i, dcd_en_i & ~orient_flip_i};
			dcd_r_q <= {dcd_en_i & orient_flip_i, dcd_en_i & ~orient_flip_i};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			chg_q <= '0;
		end else begin
			chg_q <= chg_i;
		end
	end

	assign sw_o = sw_q;
	assign clamp_en_o = clamp_q;
	assign port_out_o = pout_q;
	assign port_oe_o = poe_q;
	assign xpin_out_o = xout_q;
	assign xpin_oe_o = xoe_q;
	assign xbar_bypass_o = bypass_q;
	assign pull_up_o = pu_q;
	assign pull_dn_o = pd_q;
	assign endpoint_pullup_o = eppu_q;
	assign contact_detect_current_o = dcd_i_q;
	assign contact_detect_pulldown_o = dcd_r_q;
	assign chg_o = chg_q;
	assign ep_low_speed_o = 1'b1;
	assign ep_num_max_o = `PDM_EP_NUM_MAX;
	assign ep_dev_class_o = `PDM_EP_CLASS_BILLBOARD;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_flip_swap;
		!sys_rst_i && orient_flip_i
			|=> sw_o.top_sel == $past(route_i.bot_src) && sw_o.sbu_swap;
	endproperty
	a_flip_swap: assert property (p_flip_swap) else $error("top not swapped");

	property p_route_root;
		!sys_rst_i && route_i.bot_src == pdm_pkg::PDM_SRC_ROOT && !orient_flip_i
			|=> sw_o.bot_sel == pdm_pkg::PDM_SRC_ROOT && clamp_en_o[`PDM_PIN_BN];
	endproperty
	a_route_root: assert property (p_route_root) else $error("root not on bottom");

	property p_ser_top;
		port_oe_o[`PDM_PIN_TP] |-> sw_o.top_sel == pdm_pkg::PDM_SRC_SERIAL
			&& !port_oe_o[`PDM_PIN_TN];
	endproperty
	a_ser_top: assert property (p_ser_top) else $error("top driven without serial");

	property p_sbu_flip;
		!sys_rst_i && route_i.sbu_src == pdm_pkg::PDM_SBU_SERIAL && orient_flip_i
			|=> port_oe_o[`PDM_PIN_S2] && !port_oe_o[`PDM_PIN_S1];
	endproperty
	a_sbu_flip: assert property (p_sbu_flip) else $error("sideband not swapped");

	property p_xbar_dir;
		!sys_rst_i && xbar_load_i |=> ##1 xpin_oe_o == $past(xbar_cfg_i.dir, 2);
	endproperty
	a_xbar_dir: assert property (p_xbar_dir) else $error("crossbar dir not applied");

	property p_bypass;
		(!sys_rst_i && xbar_bypass_o) ##1 xbar_bypass_o
			|-> xpin_out_o[1] == $past(xpin_in_i[0]) && xpin_oe_o == 2'h2;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass copy wrong");

	property p_cmp_en;
		(cmp_event_o & ~$past(cmp_en_i)) == 6'h00;
	endproperty
	a_cmp_en: assert property (p_cmp_en) else $error("event from disabled comparator");

	property p_pull;
		!sys_rst_i |=> pull_dn_o == $past(pull_dn_i) && (pull_up_o & pull_dn_o) == 6'h00;
	endproperty
	a_pull: assert property (p_pull) else $error("pull state wrong");

	property p_clamp;
		clamp_en_o[`PDM_PIN_S1] == (sw_o.sbu_sel != pdm_pkg::PDM_SBU_NONE);
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp without closed path");

	property p_ep_tx;
		ep_tx_i |=> endpoint_pullup_o == 2'h0;
	endproperty
	a_ep_tx: assert property (p_ep_tx) else $error("pull-up on during transmit");

	property p_ep_rx;
		!sys_rst_i && ep_attach_i && !ep_tx_i && orient_flip_i
			|=> endpoint_pullup_o == 2'h2;
	endproperty
	a_ep_rx: assert property (p_ep_rx) else $error("pull-up on wrong pair");

	property p_dcd;
		!sys_rst_i && dcd_en_i && !orient_flip_i
			|=> contact_detect_current_o == 2'h1 && contact_detect_pulldown_o == 2'h1;
	endproperty
	a_dcd: assert property (p_dcd) else $error("contact detect on wrong pair");

	property p_chg;
		!sys_rst_i |=> chg_o == $past(chg_i);
	endproperty
	a_chg: assert property (p_chg) else $error("charger switch lost");

	c_flip_serial: cover property (orient_flip_i && ch_act[0] ##1 port_oe_o[`PDM_PIN_BP]);
	c_bypass_exit: cover property (xbar_bypass_o ##1 !xbar_bypass_o);
	c_cmp_event: cover property (|cmp_event_o);

endmodule : pdm_port_mux

/* File: tb/pdm_far_end.sv */
/*
 * far-end model: the cable partner's levels on the six port pins.
 * assumes port_oe_i is high while the block drives a pin.
 */
`timescale 1ns/100ps
module pdm_far_end (
	input wire logic [5:0] port_out_i,
	input wire logic [5:0] port_oe_i,
	input wire logic [5:0] far_val_i,
	output logic [5:0] port_in_o
);
	// a driven pin shows the block's level, a released one the partner's
	assign port_in_o = (port_oe_i & port_out_i) | (~port_oe_i & far_val_i);
endmodule : pdm_far_end

/* File: tb/tb_top.sv */
/*
 * self-checking bench of the port data multiplexer control.
 * assumes the design files and the far-end model are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic orient_flip_i = 1'b0;
	logic xbar_load_i = 1'b0;
	logic ep_attach_i = 1'b0;
	logic ep_tx_i = 1'b0;
	logic dcd_en_i = 1'b0;
	pdm_pkg::pdm_route_t route_i = '0;
	pdm_pkg::pdm_xbar_t xbar_cfg_i = '0;
	pdm_pkg::pdm_chg_t chg_i = '0;
	pdm_pkg::pdm_chg_t chg_o;
	pdm_pkg::pdm_sw_t sw_o;
	logic [5:0] cmp_en_i = 6'h00;
	logic [5:0] pull_up_i = 6'h00;
	logic [5:0] pull_dn_i = 6'h00;
	logic [5:0] far = 6'h3f;
	logic [5:0] port_in_i, port_out_o, port_oe_o, cmp_event_o, pull_up_o, pull_dn_o, clamp_en_o;
	logic [1:0] xtb = 2'h3;
	logic [1:0] xpin_in_i, xpin_out_o, xpin_oe_o, endpoint_pullup_o;
	logic [1:0] contact_detect_current_o, contact_detect_pulldown_o;
	logic xbar_bypass_o, ep_low_speed_o;
	logic [7:0] ep_dev_class_o;
	logic [3:0] ep_num_max_o;
	int err_count = 0;
	int n_compared = 0;
	int c2, c3;

	always #20 clk_sys_i = ~clk_sys_i;
	// external serial pins: the bench drives only those the crossbar leaves as inputs
	assign xpin_in_i = (xpin_oe_o & xpin_out_o) | (~xpin_oe_o & xtb);

	pdm_port_mux i_pdm_port_mux (.clk_sys_i, .sys_rst_i, .orient_flip_i, .route_i, .sw_o,
		.port_in_i, .port_out_o, .port_oe_o, .xpin_in_i, .xpin_out_o, .xpin_oe_o,
		.xbar_cfg_i, .xbar_load_i, .xbar_bypass_o, .cmp_en_i, .cmp_event_o, .pull_up_i,
		.pull_dn_i, .pull_up_o, .pull_dn_o, .clamp_en_o, .ep_attach_i, .ep_tx_i,
		.endpoint_pullup_o, .ep_low_speed_o, .ep_dev_class_o, .ep_num_max_o, .dcd_en_i,
		.contact_detect_current_o, .contact_detect_pulldown_o, .chg_i, .chg_o);

	pdm_far_end i_pdm_far_end (.port_out_i(port_out_o), .port_oe_i(port_oe_o),
		.far_val_i(far), .port_in_o(port_in_i));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step

	task automatic set_route(input pdm_pkg::pdm_src_t t, input pdm_pkg::pdm_src_t b,
		input pdm_pkg::pdm_sbu_src_t s, input logic f);
		@(posedge clk_sys_i);
		route_i <= '{t, b, s};
		orient_flip_i <= f;
		step(2);
	endtask : set_route

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		err_count++;
		$display("mismatch watchdog expected done seen hang");
		report_and_stop();
	end

	initial begin
		repeat (20) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		step(2);
		chk("bypass", xbar_bypass_o, 1);
		chk("xpin_oe", xpin_oe_o, 2'h2);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys_i);
			xtb <= {1'b1, v[0]};
			step(3);
			chk("bypass_copy", xpin_out_o[1], v);
		end
		chk("low_speed", ep_low_speed_o, 1);
		chk("ep_max", ep_num_max_o, 4'h0);
		chk("ep_class", ep_dev_class_o, 8'h11);
		$display("test power-up done");

		set_route(pdm_pkg::PDM_SRC_ROOT, pdm_pkg::PDM_SRC_AUX, pdm_pkg::PDM_SBU_AUX, 1'b0);
		chk("sw", sw_o, {pdm_pkg::PDM_SRC_ROOT, pdm_pkg::PDM_SRC_AUX, pdm_pkg::PDM_SBU_AUX, 1'b0});
		chk("clamp", clamp_en_o, 6'h3f);
		set_route(pdm_pkg::PDM_SRC_ROOT, pdm_pkg::PDM_SRC_AUX, pdm_pkg::PDM_SBU_AUX, 1'b1);
		chk("sw", sw_o, {pdm_pkg::PDM_SRC_AUX, pdm_pkg::PDM_SRC_ROOT, pdm_pkg::PDM_SBU_AUX, 1'b1});
		set_route(pdm_pkg::PDM_SRC_NONE, pdm_pkg::PDM_SRC_ENDPT, pdm_pkg::PDM_SBU_NONE, 1'b0);
		chk("sw", sw_o, {pdm_pkg::PDM_SRC_NONE, pdm_pkg::PDM_SRC_ENDPT, pdm_pkg::PDM_SBU_NONE, 1'b0});
		chk("clamp", clamp_en_o, 6'h0c);
		$display("test routing done");

		@(posedge clk_sys_i);
		xbar_cfg_i <= '{2'h2, 2'h1, 2'h1};
		xbar_load_i <= 1'b1;
		@(posedge clk_sys_i);
		xbar_load_i <= 1'b0;
		step(2);
		chk("bypass", xbar_bypass_o, 0);
		chk("xpin_oe", xpin_oe_o, 2'h2);
		// pin 0 feeds channel 0 transmit, pin 1 carries channel 0 receive
		for (int v = 0; v < 4; v++) begin
			// channel 2 is unmapped in the crossbar, so the sideband idles high
			set_route(pdm_pkg::PDM_SRC_SERIAL, pdm_pkg::PDM_SRC_NONE,
				pdm_pkg::PDM_SBU_SERIAL, v[1]);
			@(posedge clk_sys_i);
			xtb <= {1'b1, v[0]};
			far <= {6{~v[0]}};
			step(4);
			chk("ser_tx", v[1] ? port_out_o[2] : port_out_o[0], v[0]);
			chk("ser_rx", xpin_out_o[1], !v[0]);
			chk("ser_oe", port_oe_o, v[1] ? 6'h24 : 6'h11);
			chk("ser_sbu_idle", v[1] ? port_out_o[5] : port_out_o[4], 1'b1);
		end
		$display("test serial done");

		set_route(pdm_pkg::PDM_SRC_SERIAL, pdm_pkg::PDM_SRC_NONE, pdm_pkg::PDM_SBU_NONE, 1'b0);
		@(posedge clk_sys_i);
		cmp_en_i <= 6'h04;
		far <= 6'h3f;
		step(3);
		@(posedge clk_sys_i);
		far <= 6'h33;
		c2 = 0;
		c3 = 0;
		repeat (6) begin
			step(1);
			c2 += (cmp_event_o[2] === 1'b1);
			c3 += (cmp_event_o[3] !== 1'b0);
		end
		chk("cmp_on", c2, 1);
		chk("cmp_off", c3, 0);
		$display("test comparator done");

		@(posedge clk_sys_i);
		pull_up_i <= 6'h0f;
		pull_dn_i <= 6'h03;
		step(2);
		chk("pull_up", pull_up_o, 6'h0c);
		chk("pull_dn", pull_dn_o, 6'h03);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys_i);
			ep_attach_i <= 1'b1;
			orient_flip_i <= k[0];
			ep_tx_i <= k[1];
			step(2);
			chk("ep_pullup", endpoint_pullup_o, k == 2 ? 2'h0 : (k == 1 ? 2'h2 : 2'h1));
		end
		chk("ep_tx_pullup", endpoint_pullup_o, 2'h0);
		for (int f = 0; f < 2; f++) begin
			@(posedge clk_sys_i);
			dcd_en_i <= 1'b1;
			orient_flip_i <= f[0];
			step(2);
			chk("dcd_cur", contact_detect_current_o, f ? 2'h2 : 2'h1);
			chk("dcd_pd", contact_detect_pulldown_o, f ? 2'h2 : 2'h1);
		end
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys_i);
			chg_i <= pdm_pkg::pdm_chg_t'(12'h001 << i);
			step(2);
			chk("charger", chg_o, 12'h001 << i);
		end
		$display("test pulls endpoint charger done");
		// reset in mid-run: switch, clamp, enable, pull and charger outputs clear and the bypass comes back
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		step(2);
		chk("rst_bypass", xbar_bypass_o, 1);
		chk("rst_xpin_oe", xpin_oe_o, 2'h0);
		chk("rst_sw", sw_o, 9'h000);
		chk("rst_clamp", clamp_en_o, 6'h00);
		chk("rst_port_oe", port_oe_o, 6'h00);
		chk("rst_pull", {pull_up_o, pull_dn_o}, 12'h000);
		chk("rst_charger", chg_o, 12'h000);
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		step(2);
		chk("bypass", xbar_bypass_o, 1);
		chk("xpin_oe", xpin_oe_o, 2'h2);
		$display("test reset done");
		report_and_stop();
	end
endmodule : tb_top
